// file: common/cmpc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the mode/power controller.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH
`define CMPC_ADDR_CTRL 12'h000
`define CMPC_ADDR_STATUS 12'h004
`define CMPC_ADDR_CONFIG 12'h008
`define CMPC_BIT_INIT_REQ 0
`define CMPC_BIT_SLEEP_REQ 1
`define CMPC_BIT_WAKE_EN 2
`define CMPC_BIT_STOP_WAIT 3
`define CMPC_BIT_LISTEN 4
`define CMPC_BIT_WAKE_IRQ_EN 5
`define CMPC_BIT_MODULE_ON 7
`define CMPC_BIT_INIT_ACK 0
`define CMPC_BIT_SLEEP_ACK 1
`define CMPC_BIT_PDOWN 2
`define CMPC_BIT_RESYNC 3
`define CMPC_BIT_RECOVER 4
`define CMPC_BIT_WAKE_ARMED 5
`define CMPC_CONFIG_RESET 8'h00
`define CMPC_INIT_SYNC_CYC 4'd5
`define CMPC_SLEEP_SYNC_CYC 4'd2
`define CMPC_RECOVER_CYC 4'd4
`define CMPC_RESYNC_BITS 4'd11
`endif

// file: common/cmpc_pkg.sv
// Types of the mode/power controller.
// Assumes nothing beyond a SystemVerilog compiler.
package cmpc_pkg;
	typedef enum logic [2:0] {ST_NORMAL, ST_SLEEP_PEND, ST_SLEEP, ST_RESYNC, ST_INIT_SYNC, ST_INIT, ST_PDOWN,
		ST_RECOVER} cmpc_state_t;
	typedef enum logic [1:0] {CPU_RUN, CPU_WAIT, CPU_STOP} cmpc_cpu_t;
endpackage : cmpc_pkg

// file: design/cmpc_top.sv
// Mode and low-power control of a CAN controller: listen-only, sleep, power-down, init handshake.
// Assumes a protocol engine on the same clock that obeys the allow/enable strobes given here.
//
// Contract
// - Listen-only receives, drives recessive, never transmits.
// - Listen-only dominant bits loop back internally.
// - Module off gates all controller clocks.
// - Sleep keeps register clock; power-down stops all.
// - Wake interrupt needs all four enables set.
// - CPU mode and stop-in-wait select power-down.
// - CPU stop forces power-down while the module is on.
// - Leaving wait power-down restarts, returns normal.
// - Sleep waits until all transmit buffers empty.
// - Sleep during reception waits for bus idle.
// - Idle sleep request enters after sync delay.
// - Sleep acknowledge set once sleep active.
// - Bus-off recovery counting pauses while asleep.
// - No receive buffer copy during sleep.
// - No message abort during sleep.
// - Wake disabled masks receive input while asleep.
// - Leave sleep on bus activity or clear.
// - After wake await eleven recessive bits.
// - Deferred actions execute upon wake-up.
// - Init aborts traffic, forces transmit recessive.
// - Init stops engine, resets control, unlocks config.
// - Init request synchronised; acknowledge after all domains.
// - Protected registers ignore writes outside init.
// - Power-down stops transfers; recovery unless asleep.
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_cfg.svh"
module cmpc_top import cmpc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] cpu_mode,
	input wire logic rx_pin,
	input wire logic bit_tick,
	input wire logic proto_tx,
	input wire logic tx_pending,
	input wire logic eng_tx_busy,
	input wire logic eng_rx_busy,
	input wire logic bus_idle,
	input wire logic bus_off,
	output logic tx_pin,
	output logic rx_to_engine,
	output logic engine_clk_en,
	output logic reg_clk_en,
	output logic abort_all,
	output logic regs_default,
	output logic start_tx_allow,
	output logic copy_allow,
	output logic abort_allow,
	output logic busoff_count_en,
	output logic wakeup_irq,
	output logic [7:0] config_out
);
	cmpc_state_t st, next_st;
	logic init_request, sleep_request, wakeup_enable, stop_in_wait, listen_only, wakeup_irq_enable;
	logic module_on, module_on_written, init_ack, sleep_ack, wake_armed, pd_from_sleep, rx_prev;
	logic [3:0] cnt, rsync_cnt;
	logic [7:0] cfg;
	logic acc, wr, pd_cond, quiet, bus_wake, wake_hit;

	// APB access phase completes on the cycle after setup; writes land here.
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign pd_cond = module_on & ((cpu_mode == CPU_STOP) | ((cpu_mode == CPU_WAIT) & stop_in_wait));
	assign quiet = ~tx_pending & ~eng_tx_busy & ~eng_rx_busy & bus_idle;
	assign bus_wake = wake_armed & ~rx_pin;
	assign wake_hit = wake_armed & ~rx_pin & rx_prev & sleep_request & sleep_ack & wakeup_irq_enable &
		((st == ST_SLEEP) | (st == ST_PDOWN));

	// Next operating state; power-down has priority over init, init over sleep.
	always_comb begin
		next_st = st;
		if (pd_cond && st != ST_PDOWN) begin
			next_st = ST_PDOWN;
		end else begin
			unique case (st)
				ST_NORMAL: begin
					if (init_request) next_st = ST_INIT_SYNC;
					else if (sleep_request) next_st = ST_SLEEP_PEND;
				end
				ST_SLEEP_PEND: begin
					if (init_request) next_st = ST_INIT_SYNC;
					else if (quiet && cnt == 4'd0) next_st = ST_SLEEP;
				end
				ST_SLEEP: begin
					if (init_request) next_st = ST_INIT_SYNC;
					else if (!sleep_request || bus_wake) next_st = ST_RESYNC;
				end
				ST_RESYNC: begin
					if (init_request) next_st = ST_INIT_SYNC;
					else if (rsync_cnt == `CMPC_RESYNC_BITS) next_st = ST_NORMAL;
				end
				ST_INIT_SYNC: begin
					if (cnt == 4'd0) next_st = ST_INIT;
				end
				ST_INIT: begin
					if (!init_request) next_st = ST_RESYNC;
				end
				ST_PDOWN: begin
					if (!pd_cond) next_st = pd_from_sleep ? ST_SLEEP : ST_RECOVER;
				end
				ST_RECOVER: begin
					if (cnt == 4'd0) next_st = ST_NORMAL;
				end
			endcase
		end
	end

	// State register; out of reset the controller sits in init mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_INIT;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// Delay counter for the init synchronisation, sleep synchronisation and recovery cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'd0;
		end else if (ce) begin
			if (next_st != st) begin
				unique case (next_st)
					ST_INIT_SYNC: cnt <= `CMPC_INIT_SYNC_CYC - 4'd1;
					ST_SLEEP_PEND: cnt <= `CMPC_SLEEP_SYNC_CYC - 4'd1;
					ST_RECOVER: cnt <= `CMPC_RECOVER_CYC - 4'd1;
					default: cnt <= 4'd0;
				endcase
			end else if (st == ST_SLEEP_PEND && !quiet) begin
				cnt <= `CMPC_SLEEP_SYNC_CYC - 4'd1;
			end else if (cnt != 4'd0) begin
				cnt <= cnt - 4'd1;
			end
		end
	end

	// Counts consecutive recessive bits before rejoining the bus.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsync_cnt <= 4'd0;
		end else if (ce) begin
			if (st != ST_RESYNC) rsync_cnt <= 4'd0;
			else if (bit_tick && !rx_pin) rsync_cnt <= 4'd0;
			else if (bit_tick && rsync_cnt != `CMPC_RESYNC_BITS) rsync_cnt <= rsync_cnt + 4'd1;
		end
	end

	// Wake arming is taken when sleep is entered; later writes wait for the next sleep.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_armed <= 1'b0;
			pd_from_sleep <= 1'b0;
			rx_prev <= 1'b1;
		end else if (ce) begin
			rx_prev <= rx_pin;
			if (next_st == ST_SLEEP && st != ST_SLEEP) wake_armed <= wakeup_enable;
			else if (next_st != ST_SLEEP && next_st != ST_PDOWN) wake_armed <= 1'b0;
			if (next_st == ST_PDOWN && st != ST_PDOWN) pd_from_sleep <= (st == ST_SLEEP);
		end
	end

	// Control bits; in init the control bits other than the request return to defaults.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_request <= 1'b1;
			sleep_request <= 1'b0;
			wakeup_enable <= 1'b0;
			stop_in_wait <= 1'b0;
			wakeup_irq_enable <= 1'b0;
		end else if (ce) begin
			if (wr && paddr == `CMPC_ADDR_CTRL) begin
				if (pwdata[`CMPC_BIT_INIT_REQ] || init_ack) init_request <= pwdata[`CMPC_BIT_INIT_REQ];
				if (pwdata[`CMPC_BIT_SLEEP_REQ] || sleep_ack) sleep_request <= pwdata[`CMPC_BIT_SLEEP_REQ];
				wakeup_enable <= pwdata[`CMPC_BIT_WAKE_EN];
				stop_in_wait <= pwdata[`CMPC_BIT_STOP_WAIT];
				wakeup_irq_enable <= pwdata[`CMPC_BIT_WAKE_IRQ_EN];
			end
			if (st == ST_SLEEP && next_st == ST_RESYNC) sleep_request <= 1'b0;
			if (st == ST_INIT) begin
				sleep_request <= 1'b0;
				wakeup_enable <= 1'b0;
				stop_in_wait <= 1'b0;
				wakeup_irq_enable <= 1'b0;
			end
		end
	end

	// Protected bits; writable only while init is acknowledged, module enable only once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			listen_only <= 1'b0;
			module_on <= 1'b0;
			module_on_written <= 1'b0;
			cfg <= `CMPC_CONFIG_RESET;
		end else if (ce) begin
			if (wr && init_ack && paddr == `CMPC_ADDR_CTRL) begin
				listen_only <= pwdata[`CMPC_BIT_LISTEN];
				if (!module_on_written) begin
					module_on <= pwdata[`CMPC_BIT_MODULE_ON];
					module_on_written <= 1'b1;
				end
			end
			if (wr && init_ack && paddr == `CMPC_ADDR_CONFIG) cfg <= pwdata[7:0];
		end
	end

	// Acknowledges follow the state that the controller has reached.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_ack <= 1'b1;
			sleep_ack <= 1'b0;
		end else if (ce) begin
			init_ack <= (next_st == ST_INIT);
			sleep_ack <= (next_st == ST_SLEEP) || (next_st == ST_PDOWN && sleep_ack);
		end
	end

	// Pin, clock and engine strobes, registered from the next state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pin <= 1'b1;
			rx_to_engine <= 1'b1;
			engine_clk_en <= 1'b0;
			reg_clk_en <= 1'b0;
			abort_all <= 1'b0;
			regs_default <= 1'b0;
			start_tx_allow <= 1'b0;
			copy_allow <= 1'b0;
			abort_allow <= 1'b0;
			busoff_count_en <= 1'b0;
			wakeup_irq <= 1'b0;
		end else if (ce) begin
			tx_pin <= (next_st inside {ST_NORMAL, ST_SLEEP_PEND}) && module_on && !listen_only ? proto_tx : 1'b1;
			if (next_st == ST_SLEEP && !wake_armed && st == ST_SLEEP) rx_to_engine <= 1'b1;
			else if (listen_only) rx_to_engine <= rx_pin & proto_tx;
			else rx_to_engine <= rx_pin;
			engine_clk_en <= module_on && (next_st inside {ST_NORMAL, ST_SLEEP_PEND, ST_RESYNC, ST_INIT_SYNC,
				ST_RECOVER});
			reg_clk_en <= module_on && next_st != ST_PDOWN;
			abort_all <= (next_st == ST_INIT_SYNC || next_st == ST_PDOWN) && st != next_st;
			regs_default <= (next_st == ST_INIT);
			start_tx_allow <= module_on && !listen_only && next_st == ST_NORMAL;
			copy_allow <= module_on && (next_st inside {ST_NORMAL, ST_SLEEP_PEND, ST_RESYNC});
			abort_allow <= module_on && (next_st inside {ST_NORMAL, ST_SLEEP_PEND, ST_RESYNC});
			busoff_count_en <= bus_off && module_on && (next_st inside {ST_NORMAL, ST_SLEEP_PEND, ST_RESYNC});
			wakeup_irq <= wake_hit;
		end
	end

	// APB slave: no wait state, read data captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~(paddr inside {`CMPC_ADDR_CTRL, `CMPC_ADDR_STATUS, `CMPC_ADDR_CONFIG});
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				unique case (paddr)
					`CMPC_ADDR_CTRL: begin
						prdata[`CMPC_BIT_INIT_REQ] <= init_request;
						prdata[`CMPC_BIT_SLEEP_REQ] <= sleep_request;
						prdata[`CMPC_BIT_WAKE_EN] <= wakeup_enable;
						prdata[`CMPC_BIT_STOP_WAIT] <= stop_in_wait;
						prdata[`CMPC_BIT_LISTEN] <= listen_only;
						prdata[`CMPC_BIT_WAKE_IRQ_EN] <= wakeup_irq_enable;
						prdata[`CMPC_BIT_MODULE_ON] <= module_on;
					end
					`CMPC_ADDR_STATUS: begin
						prdata[`CMPC_BIT_INIT_ACK] <= init_ack;
						prdata[`CMPC_BIT_SLEEP_ACK] <= sleep_ack;
						prdata[`CMPC_BIT_PDOWN] <= (st == ST_PDOWN);
						prdata[`CMPC_BIT_RESYNC] <= (st == ST_RESYNC);
						prdata[`CMPC_BIT_RECOVER] <= (st == ST_RECOVER);
						prdata[`CMPC_BIT_WAKE_ARMED] <= wake_armed;
					end
					`CMPC_ADDR_CONFIG: prdata[7:0] <= cfg;
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration image handed to bit timing and filters.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) config_out <= `CMPC_CONFIG_RESET;
		else if (ce) config_out <= cfg;
	end

	// Checks; a frozen clock enable suspends them.
	sequence init_wait_s;
		(st == ST_INIT_SYNC && !init_ack) [*5];
	endsequence
	sequence init_done_s;
		st == ST_INIT && init_ack;
	endsequence

	AST_LISTEN_RECESSIVE: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		listen_only |=> tx_pin && !start_tx_allow) else $error("Listen-only drove or started a transmit.");
	AST_LOOPBACK: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		listen_only && st == ST_NORMAL && !proto_tx |=> !rx_to_engine) else $error("Dominant bit not looped back.");
	AST_CLOCKS_OFF: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		!module_on |=> !engine_clk_en && !reg_clk_en) else $error("Clocks run with module off.");
	AST_WAKE_IRQ: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		wakeup_irq |-> $past(sleep_request) && $past(sleep_ack) && $past(wake_armed) && $past(wakeup_irq_enable))
		else $error("Wake interrupt without all enables.");
	AST_STOP_PDOWN: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		module_on && cpu_mode == CPU_STOP |=> st == ST_PDOWN && tx_pin) else $error("Stop did not force power-down.");
	AST_SLEEP_WAITS: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		st == ST_SLEEP_PEND && (tx_pending || eng_rx_busy) |=> st != ST_SLEEP) else $error("Slept with traffic.");
	AST_SLEEP_ACK: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		$rose(sleep_ack) |-> st == ST_SLEEP && $past(st == ST_SLEEP_PEND)) else $error("Sleep ack out of order.");
	AST_RX_MASK: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		st == ST_SLEEP && $past(st == ST_SLEEP) && !wake_armed |=> rx_to_engine) else $error("Receive not masked.");
	AST_INIT_SYNC: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		$rose(st == ST_INIT_SYNC) |-> init_wait_s ##1 init_done_s) else $error("Init handshake delay wrong.");
	AST_CFG_LOCK: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		wr && !init_ack |=> $stable(cfg) && $stable(listen_only)) else $error("Protected write accepted.");
	AST_RESYNC_TX: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		st == ST_RESYNC |-> !start_tx_allow && tx_pin) else $error("Transmit allowed before resync.");
endmodule : cmpc_top
`default_nettype wire

// file: bench/cmpc_bus_node.sv
// Far-side CAN node: a free bit timer and short frames on the receive line.
// Assumes a wired-and bus with pull-up and four clocks per bit time.
`timescale 1ns/1ps
`default_nettype none
module cmpc_bus_node (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tx_pin,
	input wire logic send,
	output logic rx_pin,
	output logic bit_tick
);
	logic [1:0] div;
	logic [3:0] left;
	// Bit timer, and a frame of six bits that alternate dominant and recessive.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 2'h0;
			left <= 4'h0;
		end else begin
			div <= div + 2'h1;
			if (send && left == 4'h0) begin
				left <= 4'h6;
			end else if (div == 2'h3 && left != 4'h0) begin
				left <= left - 4'h1;
			end
		end
	end
	// The bus idles recessive through its pull-up.
	assign bit_tick = (div == 2'h3);
	assign rx_pin = tx_pin & ~(left != 4'h0 && !left[0]);
endmodule : cmpc_bus_node
`default_nettype wire

// file: bench/cmpc_top_tb_top.sv
// Self-checking bench of the mode and power controller.
// Assumes the controller package, the offsets header and the bus node model.
`timescale 1ns/1ps
`default_nettype none
`include "cmpc_cfg.svh"
module cmpc_top_tb_top import cmpc_pkg::*;;
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cmpc_exp_t;
	localparam logic [11:0] CT = `CMPC_ADDR_CTRL;
	localparam logic [11:0] ST = `CMPC_ADDR_STATUS;
	localparam logic [11:0] CF = `CMPC_ADDR_CONFIG;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, send, rx_pin, bit_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [1:0] cpu_mode;
	logic proto_tx, tx_pending, eng_tx_busy, eng_rx_busy, bus_idle, bus_off, tx_pin, rx_to_engine;
	logic engine_clk_en, reg_clk_en, abort_all, regs_default, start_tx_allow, copy_allow;
	logic abort_allow, busoff_count_en, wakeup_irq;
	logic [7:0] config_out, cfg;
	int failures = 0, n_compared = 0, n_abort = 0, n_irq = 0, n_rx0 = 0, n, k;
	cmpc_exp_t expq[$];

	cmpc_top u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_mode(cpu_mode), .rx_pin(rx_pin), .bit_tick(bit_tick),
		.proto_tx(proto_tx), .tx_pending(tx_pending), .eng_tx_busy(eng_tx_busy),
		.eng_rx_busy(eng_rx_busy), .bus_idle(bus_idle), .bus_off(bus_off), .tx_pin(tx_pin),
		.rx_to_engine(rx_to_engine), .engine_clk_en(engine_clk_en), .reg_clk_en(reg_clk_en),
		.abort_all(abort_all), .regs_default(regs_default), .start_tx_allow(start_tx_allow),
		.copy_allow(copy_allow), .abort_allow(abort_allow), .busoff_count_en(busoff_count_en),
		.wakeup_irq(wakeup_irq), .config_out(config_out));
	cmpc_bus_node u_node (.pclk(pclk), .presetn(presetn), .tx_pin(tx_pin), .send(send),
		.rx_pin(rx_pin), .bit_tick(bit_tick));

	// Clock of 100 MHz.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic bad(input string msg);
		failures++;
		$display("MISMATCH %0t %s", $time, msg);
	endtask : bad

	task automatic chk(input logic got, input logic exp, input string msg);
		n_compared++;
		if (got !== exp) bad(msg);
	endtask : chk

	task automatic cmp_rd(input cmpc_exp_t e);
		n_compared++;
		if ((prdata & e.m) !== e.d || pslverr !== e.e) bad("read data or error");
	endtask : cmp_rd

	task automatic final_report();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	// One APB transfer; the expected answer is noted first for the monitor.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic [31:0] em, input logic ee);
		int i = 0;
		expq.push_back('{ed, em, ee});
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (pready !== 1'b1) begin
			bad("no pready");
			final_report();
		end else begin
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask : wr

	task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask : rdx

	// Reads status until one bit reaches a value, within a bound.
	task automatic poll(input int b, input logic v);
		int i = 0;
		do begin
			rdx(ST, 32'h0, 32'h0);
			i++;
		end while (rd[b] !== v && i < 60);
		chk(rd[b], v, "status bit wait");
		if (rd[b] !== v) final_report();
	endtask : poll

	task automatic frame();
		send <= 1'b1;
		@(posedge pclk);
		send <= 1'b0;
		repeat (40) @(posedge pclk);
	endtask : frame

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Completed transfers are checked against the oldest note.
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (expq.size() > 0) cmp_rd(expq.pop_front());
			else bad("unexpected transfer");
		end
	end

	// Pulse and loop-back counters.
	always @(posedge pclk) begin
		if (abort_all === 1'b1) n_abort++;
		if (wakeup_irq === 1'b1) n_irq++;
		if (rx_to_engine === 1'b0) n_rx0++;
	end

	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, cpu_mode, send, bus_off} = '0;
		{proto_tx, tx_pending, eng_tx_busy, eng_rx_busy, bus_idle} = 5'b10001;
		seed = 32'h0001097a;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		chk(tx_pin, 1'b1, "reset tx level");
		chk(engine_clk_en, 1'b0, "module off clock");
		rdx(ST, 32'h1, 32'h1);
		wr(CT, 32'h81);
		for (k = 0; k < 3; k++) begin
			seed = xs(seed);
			cfg = seed[7:0];
			wr(CF, {24'h0, cfg});
			rdx(CF, {24'h0, cfg}, 32'hff);
		end
		chk(regs_default, 1'b1, "init defaults");
		wr(CT, 32'h80);
		poll(0, 1'b0);
		poll(3, 1'b0);
		wr(CF, {24'h0, ~cfg});
		rdx(CF, {24'h0, cfg}, 32'hff);
		chk(config_out === cfg, 1'b1, "config image");
		apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'h0, 1'b1);
		proto_tx <= 1'b0;
		repeat (3) @(posedge pclk);
		chk(tx_pin, 1'b0, "normal transmit");
		{proto_tx, tx_pending, eng_tx_busy, eng_rx_busy, bus_idle} <= 5'b11110;
		wr(CT, 32'h82);
		repeat (10) @(posedge pclk);
		wr(CT, 32'h80);
		rdx(CT, 32'h2, 32'h2);
		rdx(ST, 32'h0, 32'h2);
		{tx_pending, eng_tx_busy} <= 2'b00;
		repeat (10) @(posedge pclk);
		rdx(ST, 32'h0, 32'h2);
		{eng_rx_busy, bus_idle, bus_off} <= 3'b011;
		poll(1, 1'b1);
		chk(engine_clk_en, 1'b0, "sleep engine clock");
		chk(reg_clk_en, 1'b1, "sleep register clock");
		chk(copy_allow, 1'b0, "sleep copy");
		chk(abort_allow, 1'b0, "sleep abort");
		chk(busoff_count_en, 1'b0, "sleep bus-off count");
		chk(tx_pin, 1'b1, "sleep tx level");
		n = n_rx0;
		frame();
		chk(n_rx0 == n, 1'b1, "masked receive");
		rdx(ST, 32'h2, 32'h2);
		wr(CT, 32'h80);
		poll(1, 1'b0);
		rdx(ST, 32'h8, 32'h8);
		poll(3, 1'b0);
		chk(copy_allow, 1'b1, "deferred copy");
		chk(busoff_count_en, 1'b1, "bus-off count resumes");
		bus_off <= 1'b0;
		for (k = 0; k < 2; k++) begin
			wr(CT, (k == 1) ? 32'ha6 : 32'h86);
			poll(1, 1'b1);
			n = n_irq;
			frame();
			chk(n_irq - n == k, 1'b1, "wake interrupt");
			poll(1, 1'b0);
			poll(3, 1'b0);
		end
		wr(CT, 32'h88);
		n = n_abort;
		cpu_mode <= 2'h1;
		repeat (3) @(posedge pclk);
		chk(reg_clk_en, 1'b0, "power-down clocks");
		chk(n_abort - n == 1, 1'b1, "power-down abort");
		chk(tx_pin, 1'b1, "power-down tx level");
		cpu_mode <= 2'h0;
		repeat (10) @(posedge pclk);
		poll(4, 1'b0);
		chk(engine_clk_en, 1'b1, "restart after wait");
		wr(CT, 32'h80);
		cpu_mode <= 2'h1;
		repeat (3) @(posedge pclk);
		chk(engine_clk_en, 1'b1, "wait keeps normal");
		cpu_mode <= 2'h2;
		repeat (3) @(posedge pclk);
		chk(reg_clk_en, 1'b0, "stop powers down");
		cpu_mode <= 2'h0;
		repeat (10) @(posedge pclk);
		poll(4, 1'b0);
		wr(CT, 32'h82);
		poll(1, 1'b1);
		n = n_abort;
		wr(CT, 32'h81);
		k = 0;
		while (regs_default !== 1'b1 && k < 30) begin
			@(posedge pclk);
			k++;
		end
		chk(k >= 5 && k < 30, 1'b1, "init sync delay");
		chk(n_abort - n == 1, 1'b1, "init abort");
		wr(CT, 32'h91);
		wr(CT, 32'h90);
		poll(0, 1'b0);
		poll(3, 1'b0);
		proto_tx <= 1'b0;
		n = n_rx0;
		repeat (5) @(posedge pclk);
		chk(tx_pin, 1'b1, "listen tx level");
		chk(start_tx_allow, 1'b0, "listen no start");
		chk(n_rx0 > n, 1'b1, "listen loop-back");
		final_report();
	end
endmodule : cmpc_top_tb_top
`default_nettype wire
